// ---- design/swc_pkg.sv ----
// Notes on behaviour
// RQ1: Sleep entry clears watchdog; may keep counting
// RQ2: Sleep entry clears powerdown flag, sets timeout flag
// RQ3: CPU clock stops; low-frequency oscillator keeps running
// RQ4: Port pins hold pre-sleep drive state
// RQ5: Converter runs in sleep on dedicated oscillator
// RQ6: Non-watchdog resets still reset during sleep
// RQ7: Watchdog or interrupt wakes, execution continues
// RQ8: Wake needs source enable, ignores global enable
// RQ9: Run prefetched instruction, then vector if enabled
// RQ10: Every wake clears the watchdog counter
// RQ11: Pending enabled interrupt turns sleep into no-op
// RQ12: Interrupt during sleep entry wakes immediately
// RQ13: Watchdog ticks from low-frequency oscillator
// RQ14: Mode 11 keeps watchdog always active
// RQ15: Mode 10 active awake, off in sleep
// RQ16: Mode 01 follows software enable bit only
// RQ17: Mode 00 keeps watchdog always off
// RQ18: Period select 1 ms to 256 s, reset 2 s
// RQ19: Counter clears on reset, kick, sleep, fail, disable
// RQ20: Oscillator divider changes leave counter alone
// RQ21: Awake time-out without kick requests device reset
// RQ22: Time-out in sleep wakes and updates flags
// RQ23: Software puts no-op after sleep if needed
// RQ24: Codes double from 1:32; reserved give 1:32
// RQ25: Count per tick, time-out at prescale, restart
package swc_pkg;

  // Register map
  localparam logic [3:0] SWC_ADDR_STATUS  = 4'h0;
  localparam logic [3:0] SWC_ADDR_WDTCTRL = 4'h1;

  // Status field positions
  localparam int SWC_STATUS_TO_BIT = 4;
  localparam int SWC_STATUS_PD_BIT = 3;

  // Watchdog control fields and reset value
  localparam int         SWC_WDT_EN_BIT     = 0;
  localparam int         SWC_WDT_PS_LSB     = 1;
  localparam logic [4:0] SWC_WDT_PS_RESET   = 5'h0B;
  localparam logic       SWC_WDT_EN_RESET   = 1'b0;
  localparam logic [4:0] SWC_WDT_PS_MAXCODE = 5'h12;

  // Time base
  localparam int          SWC_LFO_HZ      = 31000;
  localparam int          SWC_BASE_MS     = 1;
  localparam logic [23:0] SWC_MIN_PRESCALE = 24'h00_0020;

  // Watchdog mode configuration
  localparam logic [1:0] SWC_MODE_OFF      = 2'b00;
  localparam logic [1:0] SWC_MODE_SOFT     = 2'b01;
  localparam logic [1:0] SWC_MODE_NOSLEEP  = 2'b10;
  localparam logic [1:0] SWC_MODE_ALWAYS   = 2'b11;

  // Interrupt vector and sizes
  localparam logic [8:0] SWC_ISR_VECTOR = 9'h004;
  localparam int         SWC_NUM_IRQ    = 6;
  localparam int         SWC_NUM_PINS   = 4;

  typedef enum logic [2:0]
  {
    SWC_AWAKE  = 3'b001,
    SWC_ASLEEP = 3'b010,
    SWC_RESUME = 3'b100
  } swc_state_e;

  typedef struct packed
  {
    logic [SWC_NUM_PINS-1:0] level;
    logic [SWC_NUM_PINS-1:0] drive;
  } swc_pins_s;

  typedef struct packed
  {
    logic [SWC_NUM_IRQ-1:0] flag;
    logic [SWC_NUM_IRQ-1:0] enable;
  } swc_irq_s;

endpackage

// ---- design/swc_sleep_wdt.sv ----
// The implementer's own choices: the address map and strobed register access.
`timescale 1ns/1ns
module swc_sleep_wdt
  import swc_pkg::*;
(
  // Clock and reset
  input  wire logic        clk,
  input  wire logic        resetn,
  // Register port
  input  wire logic [3:0]  regAddr,
  input  wire logic [7:0]  regWdata,
  input  wire logic        regWr,
  input  wire logic        regRd,
  output logic      [7:0]  regRdata,
  // Core instructions and configuration
  input  wire logic        sleepInstr,
  input  wire logic        kickInstr,
  input  wire logic [1:0]  watchdogModeCfg,
  input  wire logic        globalIrqEnable,
  input  wire swc_irq_s    irqState,
  // Oscillators and converter
  input  wire logic        lowFreqOscTick,
  input  wire logic        oscFail,
  input  wire logic        converterDedicatedOscSel,
  // Reset sources
  input  wire logic        externalResetPin,
  input  wire logic        brownoutReset,
  input  wire logic        powerOnReset,
  // Port pins
  input  wire swc_pins_s   corePins,
  output swc_pins_s        padPins,
  // Status towards core and system
  output logic             cpuClkEnable,
  output logic             lowFreqOscEnable,
  output logic             converterClkEnable,
  output logic             asleep,
  output logic             resumeExec,
  output logic             vectorReq,
  output logic      [8:0]  vectorAddr,
  output logic             deviceResetReq
);

  ////////////////////////////////////////////////////////////////////////
  // Decoding functions

  function automatic logic [23:0] prescaleOf(input logic [4:0] code);
    if (code > SWC_WDT_PS_MAXCODE)
      prescaleOf = SWC_MIN_PRESCALE; // see RQ24
    else
      prescaleOf = SWC_MIN_PRESCALE << code; // see RQ18
  endfunction

  function automatic logic activeIn(input logic [1:0] mode,
                                    input logic       swEn,
                                    input logic       sleeping);
    case (mode)
      SWC_MODE_ALWAYS:  activeIn = 1'b1;       // see RQ14
      SWC_MODE_NOSLEEP: activeIn = !sleeping;  // see RQ15
      SWC_MODE_SOFT:    activeIn = swEn;       // see RQ16
      SWC_MODE_OFF:     activeIn = 1'b0;       // see RQ17
      default:          activeIn = 1'b0;
    endcase
  endfunction

  ////////////////////////////////////////////////////////////////////////
  // State

  swc_state_e  state_reg;
  swc_state_e  state_next;
  logic [23:0] count_reg;
  logic [23:0] count_next;
  logic [4:0]  period_reg;
  logic        swEnable_reg;
  logic        toFlagN_reg;
  logic        toFlagN_next;
  logic        pdFlagN_reg;
  logic        pdFlagN_next;
  logic        vectorPending_reg;
  logic        vectorReq_reg;
  logic        resumeExec_reg;
  logic        wdtReset_reg;
  logic [7:0]  rdata_reg;
  swc_pins_s   heldPins_reg;

  ////////////////////////////////////////////////////////////////////////
  // Combinational decode

  wire logic isAwake     = (state_reg == SWC_AWAKE);
  wire logic isAsleep    = (state_reg == SWC_ASLEEP);
  // Global enable deliberately not part of the wake term
  wire logic irqPending  = |(irqState.flag & irqState.enable); // see RQ8
  wire logic wdtActive   = activeIn(watchdogModeCfg, swEnable_reg, isAsleep);
  wire logic [23:0] limit = prescaleOf(period_reg);
  wire logic wdtExpire   = wdtActive && lowFreqOscTick
                           && (count_reg == limit - 24'h00_0001); // see RQ25
  wire logic sleepNop    = isAwake && sleepInstr && irqPending;   // see RQ11
  wire logic sleepEnter  = isAwake && sleepInstr && !irqPending;
  wire logic wakeEvent   = isAsleep && (irqPending || wdtExpire); // see RQ7
  wire logic ctrlWrite   = regWr && (regAddr == SWC_ADDR_WDTCTRL);

  wire logic [7:0] statusWord = {3'b000, toFlagN_reg, pdFlagN_reg, 3'b000};
  wire logic [7:0] ctrlWord   = {2'b00, period_reg, swEnable_reg};
  wire logic [7:0] readMux    =
    (regAddr == SWC_ADDR_STATUS)  ? statusWord :
    (regAddr == SWC_ADDR_WDTCTRL) ? ctrlWord   : 8'h00;

  ////////////////////////////////////////////////////////////////////////
  // Sleep sequencing

  always_comb
  begin
    state_next = state_reg;
    case (state_reg)
      SWC_AWAKE:
        if (sleepEnter)
          state_next = SWC_ASLEEP;
      SWC_ASLEEP:
        // Wake checked from the first sleep cycle on, so a late flag wakes at once
        if (wakeEvent)
          state_next = SWC_RESUME; // see RQ12
      SWC_RESUME:
        state_next = SWC_AWAKE;
      default:
        state_next = SWC_AWAKE;
    endcase
  end

  ////////////////////////////////////////////////////////////////////////
  // Watchdog counter

  // Divider select of the fast oscillator is not an input here at all,
  // so a divider change cannot touch the count. see RQ20
  always_comb
  begin
    count_next = count_reg;
    if (!wdtActive || kickInstr || oscFail)
      count_next = 24'h00_0000;                // see RQ19
    else if (sleepEnter)
      count_next = 24'h00_0000;                // see RQ1
    else if (wakeEvent)
      count_next = 24'h00_0000;                // see RQ10
    else if (wdtExpire)
      count_next = 24'h00_0000;                // see RQ25
    else if (lowFreqOscTick)
      count_next = count_reg + 24'h00_0001;    // see RQ13
  end

  ////////////////////////////////////////////////////////////////////////
  // Status flags

  always_comb
  begin
    toFlagN_next = toFlagN_reg;
    pdFlagN_next = pdFlagN_reg;
    if (sleepEnter)
    begin
      toFlagN_next = 1'b1;                     // see RQ2
      pdFlagN_next = 1'b0;
    end
    else if (isAsleep && wdtExpire)
    begin
      toFlagN_next = 1'b0;                     // see RQ22
      pdFlagN_next = 1'b0;
    end
    else if (isAwake && kickInstr && !sleepNop)
    begin
      toFlagN_next = 1'b1;
      pdFlagN_next = 1'b1;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Registers

  always_ff @(posedge clk or negedge resetn)
  begin
    if (!resetn)
    begin
      state_reg <= SWC_AWAKE;
      count_reg <= 24'h00_0000;                // see RQ19
      toFlagN_reg <= 1'b1;
      pdFlagN_reg <= 1'b1;
    end
    else
    begin
      state_reg <= state_next;
      count_reg <= count_next;
      toFlagN_reg <= toFlagN_next;
      pdFlagN_reg <= pdFlagN_next;
    end
  end

  always_ff @(posedge clk or negedge resetn)
  begin
    if (!resetn)
    begin
      period_reg <= SWC_WDT_PS_RESET;          // see RQ18
      swEnable_reg <= SWC_WDT_EN_RESET;
    end
    else if (ctrlWrite)
    begin
      period_reg <= regWdata[SWC_WDT_PS_LSB +: 5];
      swEnable_reg <= regWdata[SWC_WDT_EN_BIT];
    end
  end

  always_ff @(posedge clk or negedge resetn)
  begin
    if (!resetn)
      rdata_reg <= 8'h00;
    else if (regRd)
      rdata_reg <= readMux;
  end

  // Wake sequence: prefetched instruction first, then the vector
  always_ff @(posedge clk or negedge resetn)
  begin
    if (!resetn)
    begin
      resumeExec_reg <= 1'b0;
      vectorPending_reg <= 1'b0;
      vectorReq_reg <= 1'b0;
    end
    else
    begin
      resumeExec_reg <= wakeEvent;             // see RQ9
      vectorPending_reg <= wakeEvent && globalIrqEnable && irqPending;
      vectorReq_reg <= vectorPending_reg;      // see RQ9
    end
  end

  // Awake expiry asks for reset; asleep expiry only wakes
  always_ff @(posedge clk or negedge resetn)
  begin
    if (!resetn)
      wdtReset_reg <= 1'b0;
    else
      wdtReset_reg <= wdtExpire && !isAsleep;  // see RQ21
  end

  // Pins latched on the entry cycle and frozen while asleep
  always_ff @(posedge clk or negedge resetn)
  begin
    if (!resetn)
      heldPins_reg <= '0;
    else if (!isAsleep)
      heldPins_reg <= corePins;                // see RQ4
  end

  ////////////////////////////////////////////////////////////////////////
  // Outputs

  assign regRdata = rdata_reg;
  assign cpuClkEnable = !isAsleep;             // see RQ3
  assign lowFreqOscEnable = 1'b1;              // see RQ3
  assign converterClkEnable = !isAsleep || converterDedicatedOscSel; // see RQ5
  assign asleep = isAsleep;
  assign resumeExec = resumeExec_reg;
  assign vectorReq = vectorReq_reg;
  assign vectorAddr = SWC_ISR_VECTOR;
  assign padPins = heldPins_reg;
  // Other reset sources are never masked by sleep
  assign deviceResetReq = wdtReset_reg || externalResetPin
                          || brownoutReset || powerOnReset; // see RQ6

endmodule

// ---- tb/swc_sleep_wdt_chk.sv ----
`timescale 1ns/1ns
module swc_sleep_wdt_chk
  import swc_pkg::*;
(
  // Inputs of the block
  input wire logic      clk,
  input wire logic      resetn,
  input wire logic      sleepInstr,
  input wire logic      globalIrqEnable,
  input wire swc_irq_s  irqState,
  input wire logic      converterDedicatedOscSel,
  input wire logic      externalResetPin,
  input wire logic      brownoutReset,
  input wire logic      powerOnReset,
  // Outputs of the block
  input wire swc_pins_s padPins,
  input wire logic      cpuClkEnable,
  input wire logic      converterClkEnable,
  input wire logic      asleep,
  input wire logic      resumeExec,
  input wire logic      vectorReq,
  input wire logic      deviceResetReq
);
  wire irqPending = |(irqState.flag & irqState.enable);
  default clocking @(posedge clk);
  endclocking
  default disable iff (!resetn);
  sleep_entry_a: assert property (
    sleepInstr && !asleep && !resumeExec && !irqPending |=> asleep) else $error("no sleep");
  sleep_noop_a: assert property (
    sleepInstr && !asleep && irqPending |=> !asleep) else $error("sleep not skipped");
  clk_stop_a: assert property (
    cpuClkEnable != asleep) else $error("core clock wrong");
  irq_wake_a: assert property (
    asleep && irqPending |=> !asleep && resumeExec) else $error("no irq wake");
  vector_gie_a: assert property (
    asleep && irqPending && globalIrqEnable |=> ##1 vectorReq) else $error("no vector");
  vector_order_a: assert property (
    vectorReq |-> $past(resumeExec)) else $error("vector before resume");
  pin_hold_a: assert property (
    asleep && $past(asleep) |-> $stable(padPins)) else $error("pins moved");
  ext_reset_a: assert property (
    externalResetPin || brownoutReset || powerOnReset |-> deviceResetReq) else $error("no reset");
  conv_clk_a: assert property (
    converterClkEnable == (!asleep || converterDedicatedOscSel)) else $error("converter clk");
  resume_pulse_a: assert property (
    resumeExec |=> !resumeExec) else $error("resume too long");
endmodule

// ---- tb/swc_core_model.sv ----
`timescale 1ns/1ns
module swc_core_model
(
  // Clock and device status
  input wire logic clk,
  input wire logic cpuClkEnable,
  // Instructions and time base
  output logic     sleepInstr = 1'b0,
  output logic     kickInstr = 1'b0,
  output logic     lowFreqOscTick = 1'b0
);
  // Gated core issues nothing; slot after sleep holds a no-op
  task automatic issue(input logic kick);
    @(posedge clk);
    sleepInstr <= !kick && cpuClkEnable;
    kickInstr <= kick && cpuClkEnable;
    @(posedge clk);
    sleepInstr <= 1'b0;
    kickInstr <= 1'b0;
  endtask
  // Slow oscillator shrunk to one pulse every other clock
  task automatic tick(input int n);
    repeat (n)
    begin
      @(posedge clk);
      lowFreqOscTick <= 1'b1;
      @(posedge clk);
      lowFreqOscTick <= 1'b0;
    end
  endtask
endmodule

// ---- tb/test_sleep_and_watchdog_control.sv ----
`timescale 1ns/1ns
module test_sleep_and_watchdog_control import swc_pkg::*;;
  logic       clk = 1'b0, resetn = 1'b0, regWr, regRd;
  logic [3:0] regAddr;
  logic [7:0] regWdata, regRdata, rd;
  logic [1:0] watchdogModeCfg;
  logic       globalIrqEnable, oscFail, converterDedicatedOscSel;
  logic       externalResetPin, brownoutReset, powerOnReset;
  swc_irq_s   irqState;
  swc_pins_s  corePins, padPins;
  logic       sleepInstr, kickInstr, lowFreqOscTick, cpuClkEnable, lowFreqOscEnable;
  logic       converterClkEnable, asleep, resumeExec, vectorReq, deviceResetReq;
  logic [8:0] vectorAddr;
  int         num_errors = 0, total_checks = 0, resets = 0, resumes = 0, vectors = 0, n;
  // Rows: write flag, address, write data, read value
  logic [20:0] rows [6] = '{21'h000018, 21'h010016, 21'h11FF3F, 21'h100018, 21'h15AA00, 21'h110101};
  // Rows: reset expected, mode, control value
  logic [10:0] modes [6] = '{11'h001, 11'h100, 11'h501, 11'h600, 11'h700, 11'h726};
  swc_sleep_wdt swc_sleep_wdt_inst (.*);
  swc_core_model swc_core_model_inst (.*);
  always #5 clk = ~clk;
  always @(posedge clk)
  begin
    resets <= resets + deviceResetReq;
    resumes <= resumes + resumeExec;
    vectors <= vectors + vectorReq;
  end
  task automatic check(input logic [8:0] seen, input logic [8:0] want);
    total_checks++;
    if (seen !== want)
    begin
      num_errors++;
      $display("[FAIL] %0t seen %h want %h", $time, seen, want);
    end
  endtask
  task automatic regWrite(input logic [3:0] a, input logic [7:0] d);
    @(posedge clk);
    regAddr <= a;
    regWdata <= d;
    regWr <= 1'b1;
    @(posedge clk);
    regWr <= 1'b0;
  endtask
  task automatic regRead(input logic [3:0] a);
    @(posedge clk);
    regAddr <= a;
    regRd <= 1'b1;
    @(posedge clk);
    regRd <= 1'b0;
    #1 rd = regRdata;
  endtask
  task automatic cyc(input int c);
    repeat (c) @(posedge clk);
    #1;
  endtask
  task automatic test_done();
    $display("Checks %0d, errors %0d", total_checks, num_errors);
    if (num_errors == 0 && total_checks > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask
  // Hang guard
  initial
  begin
    #1000000;
    num_errors++;
    test_done();
  end
  initial
  begin
    // Inputs set from the stimulus, so none is a fixed tie
    regWr <= 1'b0;
    regRd <= 1'b0;
    regAddr <= 4'h0;
    regWdata <= 8'h00;
    watchdogModeCfg <= SWC_MODE_ALWAYS;
    globalIrqEnable <= 1'b0;
    oscFail <= 1'b0;
    converterDedicatedOscSel <= 1'b0;
    externalResetPin <= 1'b0;
    brownoutReset <= 1'b0;
    powerOnReset <= 1'b0;
    irqState <= '0;
    corePins <= 8'h5A;
    repeat (3) @(posedge clk);
    resetn <= 1'b1;
    foreach (rows[i])
    begin
      if (rows[i][20])
        regWrite(rows[i][19:16], rows[i][15:8]);
      regRead(rows[i][19:16]);
      check(rd, rows[i][7:0]);
    end
    foreach (modes[i])
    begin
      watchdogModeCfg <= modes[i][9:8];
      regWrite(SWC_ADDR_WDTCTRL, modes[i][7:0]);
      swc_core_model_inst.issue(1'b1);
      n = resets;
      swc_core_model_inst.tick(31);
      cyc(3);
      check(9'(resets - n), 9'd0);
      swc_core_model_inst.tick(1);
      cyc(3);
      check(9'(resets - n), modes[i][10]);
    end
    // Counter must restart at entry, else the early ticks would wake it
    swc_core_model_inst.issue(1'b1);
    swc_core_model_inst.tick(20);
    swc_core_model_inst.issue(1'b0);
    cyc(1);
    check(cpuClkEnable, 1'b0);
    regRead(SWC_ADDR_STATUS);
    check(rd, 8'h10);
    corePins <= 8'hA5;
    n = resets;
    swc_core_model_inst.tick(31);
    cyc(1);
    check(padPins, 8'h5A);
    check(asleep, 1'b1);
    swc_core_model_inst.tick(1);
    cyc(3);
    check(9'(resets - n), 9'd0);
    check(9'(resumes), 9'd1);
    regRead(SWC_ADDR_STATUS);
    check(rd, 8'h00);
    watchdogModeCfg <= SWC_MODE_NOSLEEP;
    converterDedicatedOscSel <= 1'b1;
    swc_core_model_inst.issue(1'b0);
    swc_core_model_inst.tick(40);
    irqState <= 12'h040;
    cyc(4);
    check(asleep, 1'b1);
    globalIrqEnable <= 1'b1;
    irqState <= 12'h041;
    cyc(4);
    check(9'(resumes), 9'd2);
    check(9'(vectors), 9'd1);
    check(vectorAddr, SWC_ISR_VECTOR);
    swc_core_model_inst.issue(1'b1);
    swc_core_model_inst.issue(1'b0);
    cyc(2);
    check(asleep, 1'b0);
    regRead(SWC_ADDR_STATUS);
    check(rd, 8'h18);
    // Oscillator failure must restart the count, else 20 + 31 ticks expire
    swc_core_model_inst.issue(1'b1);
    swc_core_model_inst.tick(20);
    oscFail <= 1'b1;
    @(posedge clk);
    oscFail <= 1'b0;
    n = resets;
    swc_core_model_inst.tick(31);
    cyc(3);
    check(9'(resets - n), 9'd0);
    swc_core_model_inst.tick(1);
    cyc(3);
    check(9'(resets - n), 9'd1);
    irqState <= '0;
    for (int i = 0; i < 3; i++)
    begin
      {externalResetPin, brownoutReset, powerOnReset} <= 3'b001 << i;
      cyc(1);
      check(deviceResetReq, 1'b1);
    end
    check(lowFreqOscEnable, 1'b1);
    test_done();
  end
endmodule
bind swc_sleep_wdt swc_sleep_wdt_chk swc_sleep_wdt_chk_inst (.*);
